//--- hdl/fpec_ctrl.v
// Flash program/erase sequencer: drives the flash mode control and block
// select registers and the array over a byte bus on the system clock.
// Assumes device read data arrives the cycle after the read strobe.
//
// Summary of operation
// - Select blocks first, then write data to the target address.
// - Program pulse lasts as long as the pulse bit is set, 10 us.
// - Total program pulse time per byte stays under 1 ms.
// - Watchdog is armed before the program pulse bit is set.
// - Wait at least 4 us after setting program-verify before reading.
// - Retry program and verify at most 50 times, then fail.
// - Only addresses 0 through 7FFF may be programmed.
// - Every byte of an erase range is programmed to zero first.
// - Erase acts on selected blocks while the erase bit stays set.
// - Erase in 10 ms pulses, at most 3000 pulses.
// - Watchdog is armed before the erase bit is set.
// - Erase-verify dummy writes all-ones, then reads that location.
// - Wait 2 us after dummy write, 4 us before the first one.
// - Unerased byte repeats erase and verify, capped at 3000.
// - Prewrite stops after 50 failed verify attempts and flags error.
`include "fpec_consts.vh"

module fpec_ctrl #(
    parameter [19:0] ERASE_CYCLES = `FPEC_CYC_ERASE
) (
    // Clock and reset
    input wire I_CLK,
    input wire I_NRST,
    // Host register port
    input wire [7:0] I_REG_ADDR,
    input wire [15:0] I_REG_WDATA,
    input wire I_REG_WE,
    input wire I_REG_RE,
    output wire [15:0] O_REG_RDATA,
    // Device byte bus
    output wire [15:0] O_DEV_ADDR,
    output wire [7:0] O_DEV_WDATA,
    output wire O_DEV_WE,
    output wire O_DEV_RE,
    input wire [7:0] I_DEV_RDATA,
    // Watchdog and status
    output wire O_WDOG_ARM,
    output wire O_BUSY
);

////////////////////////////////////////////////////////////////////////////
localparam [4:0] S_IDLE = 5'h00;
localparam [4:0] S_SEL1 = 5'h01;
localparam [4:0] S_SEL2 = 5'h02;
localparam [4:0] S_LATCH = 5'h03;
localparam [4:0] S_PSET = 5'h04;
localparam [4:0] S_PWAIT = 5'h05;
localparam [4:0] S_PCLR = 5'h06;
localparam [4:0] S_PVWAIT = 5'h07;
localparam [4:0] S_RD = 5'h08;
localparam [4:0] S_RDWAIT = 5'h09;
localparam [4:0] S_PVCMP = 5'h0A;
localparam [4:0] S_EARM = 5'h0B;
localparam [4:0] S_ESET = 5'h0C;
localparam [4:0] S_EWAIT = 5'h0D;
localparam [4:0] S_ECLR = 5'h0E;
localparam [4:0] S_EVWAIT = 5'h0F;
localparam [4:0] S_DUMMY = 5'h10;
localparam [4:0] S_DWAIT = 5'h11;
localparam [4:0] S_EVCMP = 5'h12;
localparam [4:0] S_UNSEL1 = 5'h13;
localparam [4:0] S_UNSEL2 = 5'h14;

localparam [19:0] CYC_WPULSE = `FPEC_CYC_WPULSE;
localparam [19:0] CYC_WCHECK = `FPEC_CYC_WCHECK;
localparam [19:0] CYC_ECHECK = `FPEC_CYC_ECHECK;
localparam [19:0] CYC_DUMMY = `FPEC_CYC_DUMMY;
localparam [11:0] TRIES_W = `FPEC_WRITE_TRIES;
localparam [11:0] TRIES_E = `FPEC_ERASE_TRIES;
localparam [15:0] ADDR_MAX = `FPEC_DEV_ADDR_MAX;

////////////////////////////////////////////////////////////////////////////
reg [4:0] state_q;
reg [15:0] addr_q;
reg [15:0] end_q;
reg [15:0] cur_q;
reg [7:0] data_q;
reg [15:0] blksel_q;
reg [7:0] lastrd_q;
reg erasing_q;
reg ephase_q;
reg done_q;
reg fail_q;
reg range_q;
reg wdog_q;
reg [15:0] dev_addr_q;
reg [7:0] dev_wdata_q;
reg dev_we_q;
reg dev_re_q;
reg [15:0] rdata_q;
reg tmr_load;
reg [19:0] tmr_count;
reg cnt_clr;
reg cnt_inc;
wire tmr_done;
wire [11:0] tries;
wire at_limit;
wire busy;
wire go_prog;
wire go_erase;
wire [7:0] wr_byte;
wire last_addr;

assign busy = (state_q != S_IDLE);
assign go_prog = I_REG_WE && !busy && (I_REG_ADDR == `FPEC_REG_CMD) &&
    I_REG_WDATA[`FPEC_CMD_PROG_BIT] && !I_REG_WDATA[`FPEC_CMD_ERASE_BIT];
assign go_erase = I_REG_WE && !busy && (I_REG_ADDR == `FPEC_REG_CMD) &&
    I_REG_WDATA[`FPEC_CMD_ERASE_BIT] && !I_REG_WDATA[`FPEC_CMD_PROG_BIT];
// Prewrite programs zeros before an erase
assign wr_byte = erasing_q ? `FPEC_DATA_ZERO : data_q;
assign last_addr = (cur_q == end_q);

////////////////////////////////////////////////////////////////////////////
fpec_tmr #(
    .W(20)
) u_tmr (
    .i_clk(I_CLK),
    .i_nrst(I_NRST),
    .i_load(tmr_load),
    .i_count(tmr_count),
    .o_done(tmr_done)
);

fpec_cnt #(
    .W(12)
) u_cnt (
    .i_clk(I_CLK),
    .i_nrst(I_NRST),
    .i_clr(cnt_clr),
    .i_inc(cnt_inc),
    .i_limit(ephase_q ? TRIES_E : TRIES_W),
    .o_count(tries),
    .o_at_limit(at_limit)
);

// Timer loads and counter steps follow the state being left
always @* begin
    tmr_load = 1'b0;
    tmr_count = 20'h00000;
    cnt_clr = go_prog | go_erase;
    cnt_inc = 1'b0;
    case (state_q)
        S_LATCH: cnt_inc = 1'b1;
        S_PSET: begin
            tmr_load = 1'b1;
            tmr_count = CYC_WPULSE;
        end
        S_PCLR: begin
            tmr_load = 1'b1;
            tmr_count = CYC_WCHECK;
        end
        S_PVCMP: cnt_clr = (I_DEV_RDATA == wr_byte) && erasing_q;
        S_EARM: cnt_inc = 1'b1;
        S_ESET: begin
            tmr_load = 1'b1;
            tmr_count = ERASE_CYCLES;
        end
        S_ECLR: begin
            tmr_load = 1'b1;
            tmr_count = CYC_ECHECK;
        end
        S_DUMMY: begin
            tmr_load = 1'b1;
            tmr_count = CYC_DUMMY;
        end
        default: tmr_load = 1'b0;
    endcase
end

////////////////////////////////////////////////////////////////////////////
// Sequencer; every device access is a registered one-cycle strobe
always @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
        state_q <= S_IDLE;
        cur_q <= 16'h0000;
        erasing_q <= 1'b0;
        ephase_q <= 1'b0;
        done_q <= 1'b0;
        fail_q <= 1'b0;
        range_q <= 1'b0;
        wdog_q <= 1'b0;
        lastrd_q <= 8'h00;
        dev_addr_q <= 16'h0000;
        dev_wdata_q <= 8'h00;
        dev_we_q <= 1'b0;
        dev_re_q <= 1'b0;
    end else begin
        dev_we_q <= 1'b0;
        dev_re_q <= 1'b0;
        case (state_q)
            S_IDLE: begin
                if (go_prog || go_erase) begin
                    done_q <= 1'b0;
                    fail_q <= 1'b0;
                    range_q <= 1'b0;
                    erasing_q <= go_erase;
                    ephase_q <= 1'b0;
                    cur_q <= addr_q;
                    if (addr_q > ADDR_MAX || (go_erase &&
                        (end_q > ADDR_MAX || end_q < addr_q))) begin
                        fail_q <= 1'b1;
                        range_q <= 1'b1;
                    end else begin
                        state_q <= S_SEL1;
                    end
                end
            end
            S_SEL1: begin
                dev_we_q <= 1'b1;
                dev_addr_q <= `FPEC_DEV_BLKSEL1;
                dev_wdata_q <= blksel_q[7:0];
                state_q <= S_SEL2;
            end
            S_SEL2: begin
                dev_we_q <= 1'b1;
                dev_addr_q <= `FPEC_DEV_BLKSEL2;
                dev_wdata_q <= blksel_q[15:8];
                state_q <= S_LATCH;
            end
            S_LATCH: begin
                dev_we_q <= 1'b1;
                dev_addr_q <= cur_q;
                dev_wdata_q <= wr_byte;
                wdog_q <= 1'b1;
                state_q <= S_PSET;
            end
            S_PSET: begin
                dev_we_q <= 1'b1;
                dev_addr_q <= `FPEC_DEV_MODE_CTRL;
                dev_wdata_q <= `FPEC_MODE_WPULSE;
                state_q <= S_PWAIT;
            end
            S_PWAIT: begin
                if (tmr_done) begin
                    dev_we_q <= 1'b1;
                    dev_addr_q <= `FPEC_DEV_MODE_CTRL;
                    dev_wdata_q <= `FPEC_MODE_OFF;
                    state_q <= S_PCLR;
                end
            end
            S_PCLR: begin
                wdog_q <= 1'b0;
                dev_we_q <= 1'b1;
                dev_addr_q <= `FPEC_DEV_MODE_CTRL;
                dev_wdata_q <= `FPEC_MODE_WCHECK;
                state_q <= S_PVWAIT;
            end
            S_PVWAIT: begin
                if (tmr_done) begin
                    state_q <= S_RD;
                end
            end
            S_RD: begin
                dev_re_q <= 1'b1;
                dev_addr_q <= cur_q;
                state_q <= S_RDWAIT;
            end
            S_RDWAIT: begin
                state_q <= ephase_q ? S_EVCMP : S_PVCMP;
            end
            S_PVCMP: begin
                lastrd_q <= I_DEV_RDATA;
                dev_we_q <= 1'b1;
                dev_addr_q <= `FPEC_DEV_MODE_CTRL;
                dev_wdata_q <= `FPEC_MODE_OFF;
                if (I_DEV_RDATA == wr_byte) begin
                    if (!erasing_q) begin
                        state_q <= S_UNSEL1;
                    end else if (last_addr) begin
                        ephase_q <= 1'b1;
                        state_q <= S_EARM;
                    end else begin
                        cur_q <= cur_q + 16'h0001;
                        state_q <= S_LATCH;
                    end
                end else if (at_limit) begin
                    fail_q <= 1'b1;
                    state_q <= S_UNSEL1;
                end else begin
                    state_q <= S_LATCH;
                end
            end
            S_EARM: begin
                wdog_q <= 1'b1;
                state_q <= S_ESET;
            end
            S_ESET: begin
                dev_we_q <= 1'b1;
                dev_addr_q <= `FPEC_DEV_MODE_CTRL;
                dev_wdata_q <= `FPEC_MODE_ERASE;
                state_q <= S_EWAIT;
            end
            S_EWAIT: begin
                if (tmr_done) begin
                    dev_we_q <= 1'b1;
                    dev_addr_q <= `FPEC_DEV_MODE_CTRL;
                    dev_wdata_q <= `FPEC_MODE_OFF;
                    state_q <= S_ECLR;
                end
            end
            S_ECLR: begin
                wdog_q <= 1'b0;
                dev_we_q <= 1'b1;
                dev_addr_q <= `FPEC_DEV_MODE_CTRL;
                dev_wdata_q <= `FPEC_MODE_ECHECK;
                cur_q <= addr_q;
                state_q <= S_EVWAIT;
            end
            S_EVWAIT: begin
                if (tmr_done) begin
                    state_q <= S_DUMMY;
                end
            end
            S_DUMMY: begin
                dev_we_q <= 1'b1;
                dev_addr_q <= cur_q;
                dev_wdata_q <= `FPEC_DATA_ONES;
                state_q <= S_DWAIT;
            end
            S_DWAIT: begin
                if (tmr_done) begin
                    state_q <= S_RD;
                end
            end
            S_EVCMP: begin
                lastrd_q <= I_DEV_RDATA;
                if (I_DEV_RDATA == `FPEC_DATA_ONES && !last_addr) begin
                    cur_q <= cur_q + 16'h0001;
                    state_q <= S_DUMMY;
                end else begin
                    dev_we_q <= 1'b1;
                    dev_addr_q <= `FPEC_DEV_MODE_CTRL;
                    dev_wdata_q <= `FPEC_MODE_OFF;
                    if (I_DEV_RDATA == `FPEC_DATA_ONES) begin
                        state_q <= S_UNSEL1;
                    end else if (at_limit) begin
                        fail_q <= 1'b1;
                        state_q <= S_UNSEL1;
                    end else begin
                        state_q <= S_EARM;
                    end
                end
            end
            S_UNSEL1: begin
                dev_we_q <= 1'b1;
                dev_addr_q <= `FPEC_DEV_BLKSEL1;
                dev_wdata_q <= 8'h00;
                state_q <= S_UNSEL2;
            end
            S_UNSEL2: begin
                dev_we_q <= 1'b1;
                dev_addr_q <= `FPEC_DEV_BLKSEL2;
                dev_wdata_q <= 8'h00;
                done_q <= ~fail_q;
                state_q <= S_IDLE;
            end
            default: state_q <= S_IDLE;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////
// Host registers; setup writes are ignored while a sequence runs
always @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
        addr_q <= 16'h0000;
        end_q <= 16'h0000;
        data_q <= 8'h00;
        blksel_q <= 16'h0000;
    end else if (I_REG_WE && !busy) begin
        case (I_REG_ADDR)
            `FPEC_REG_ADDR: addr_q <= I_REG_WDATA;
            `FPEC_REG_END: end_q <= I_REG_WDATA;
            `FPEC_REG_DATA: data_q <= I_REG_WDATA[7:0];
            `FPEC_REG_BLKSEL: blksel_q <= I_REG_WDATA;
            default: data_q <= data_q;
        endcase
    end
end

always @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
        rdata_q <= 16'h0000;
    end else if (I_REG_RE) begin
        case (I_REG_ADDR)
            `FPEC_REG_ADDR: rdata_q <= addr_q;
            `FPEC_REG_END: rdata_q <= end_q;
            `FPEC_REG_DATA: rdata_q <= {8'h00, data_q};
            `FPEC_REG_BLKSEL: rdata_q <= blksel_q;
            `FPEC_REG_STATUS: rdata_q <= {12'h000, range_q, fail_q,
                done_q, busy};
            `FPEC_REG_TRIES: rdata_q <= {4'h0, tries};
            `FPEC_REG_LASTRD: rdata_q <= {8'h00, lastrd_q};
            default: rdata_q <= 16'h0000;
        endcase
    end else begin
        rdata_q <= 16'h0000;
    end
end

assign O_REG_RDATA = rdata_q;
assign O_DEV_ADDR = dev_addr_q;
assign O_DEV_WDATA = dev_wdata_q;
assign O_DEV_WE = dev_we_q;
assign O_DEV_RE = dev_re_q;
assign O_WDOG_ARM = wdog_q;
assign O_BUSY = busy;

endmodule

//--- hdl/fpec_consts.vh
// Constants for the flash program/erase controller.
// Assumes a 100 MHz system clock shared with the flash device bus.
`ifndef FPEC_CONSTS_VH
`define FPEC_CONSTS_VH

////////////////////////////////////////////////////////////////////////////
// Device register map (byte addresses on the device bus)
`define FPEC_DEV_MODE_CTRL 16'hFF80
`define FPEC_DEV_BLKSEL1 16'hFF82
`define FPEC_DEV_BLKSEL2 16'hFF83
`define FPEC_DEV_ADDR_MAX 16'h7FFF

// Mode control bit values: one bit set at a time
`define FPEC_MODE_OFF 8'h00
`define FPEC_MODE_WPULSE 8'h01
`define FPEC_MODE_ERASE 8'h02
`define FPEC_MODE_WCHECK 8'h04
`define FPEC_MODE_ECHECK 8'h08
`define FPEC_DATA_ZERO 8'h00
`define FPEC_DATA_ONES 8'hFF

////////////////////////////////////////////////////////////////////////////
// Host register map
`define FPEC_REG_CMD 8'h00
`define FPEC_REG_ADDR 8'h04
`define FPEC_REG_DATA 8'h08
`define FPEC_REG_BLKSEL 8'h0C
`define FPEC_REG_END 8'h10
`define FPEC_REG_STATUS 8'h14
`define FPEC_REG_TRIES 8'h18
`define FPEC_REG_LASTRD 8'h1C
`define FPEC_CMD_PROG_BIT 0
`define FPEC_CMD_ERASE_BIT 1
`define FPEC_ST_BUSY_BIT 0
`define FPEC_ST_DONE_BIT 1
`define FPEC_ST_FAIL_BIT 2
`define FPEC_ST_RANGE_BIT 3

////////////////////////////////////////////////////////////////////////////
// Timing and retry limits
`define FPEC_CLK_MHZ 100
`define FPEC_T_WPULSE_US 10
`define FPEC_T_WCHECK_US 4
`define FPEC_T_ECHECK_US 4
`define FPEC_T_DUMMY_US 2
`define FPEC_T_ERASE_MS 10
// Two spare cycles on the pulse, check and dummy counts (none on erase) cover the registered write reaching the device late
`define FPEC_CYC_WPULSE (`FPEC_T_WPULSE_US * `FPEC_CLK_MHZ + 2)
`define FPEC_CYC_WCHECK (`FPEC_T_WCHECK_US * `FPEC_CLK_MHZ + 2)
`define FPEC_CYC_ECHECK (`FPEC_T_ECHECK_US * `FPEC_CLK_MHZ + 2)
`define FPEC_CYC_DUMMY (`FPEC_T_DUMMY_US * `FPEC_CLK_MHZ + 2)
`define FPEC_CYC_ERASE (`FPEC_T_ERASE_MS * 1000 * `FPEC_CLK_MHZ)
`define FPEC_WRITE_TRIES 50
`define FPEC_ERASE_TRIES 3000

`endif

//--- hdl/fpec_tmr.v
// Down-counting delay timer for the flash sequencer.
// Assumes the caller loads it and waits for o_done.
module fpec_tmr #(
    parameter W = 20
) (
    // Clock and reset
    input wire i_clk,
    input wire i_nrst,
    // Control
    input wire i_load,
    input wire [W-1:0] i_count,
    // Status
    output wire o_done
);

reg [W-1:0] cnt_q;

always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
        cnt_q <= {W{1'b0}};
    end else if (i_load) begin
        cnt_q <= i_count;
    end else if (cnt_q != {W{1'b0}}) begin
        cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
    end
end

// Last cycle of the count; a fresh load masks a stale done
assign o_done = (cnt_q == {{(W-1){1'b0}}, 1'b1}) & ~i_load;

endmodule

//--- hdl/fpec_cnt.v
// Attempt counter with a run-time limit compare.
// Assumes clear and increment are never raised together.
module fpec_cnt #(
    parameter W = 12
) (
    // Clock and reset
    input wire i_clk,
    input wire i_nrst,
    // Control
    input wire i_clr,
    input wire i_inc,
    input wire [W-1:0] i_limit,
    // Status
    output wire [W-1:0] o_count,
    output wire o_at_limit
);

reg [W-1:0] count_q;

always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
        count_q <= {W{1'b0}};
    end else if (i_clr) begin
        count_q <= {W{1'b0}};
    end else if (i_inc) begin
        count_q <= count_q + {{(W-1){1'b0}}, 1'b1};
    end
end

assign o_count = count_q;
assign o_at_limit = (count_q == i_limit);

endmodule

//--- bench/fpec_ctrl_asserts.sv
// Checker for device-bus order and timing of the flash sequencer.
// Assumes it is bound to fpec_ctrl and sees only that module's ports.
module fpec_ctrl_asserts (
    // Clock and reset
    input wire I_CLK,
    input wire I_NRST,
    // Device byte bus
    input wire [15:0] O_DEV_ADDR,
    input wire [7:0] O_DEV_WDATA,
    input wire O_DEV_WE,
    input wire O_DEV_RE,
    // Watchdog
    input wire O_WDOG_ARM
);
    timeunit 1ns;
    timeprecision 1ps;
    reg [7:0] mode_q;
    reg [15:0] gap_q;
    reg [15:0] last_q;
    reg [15:0] lat_q;
    reg [15:0] plen_q;
    wire mode_wr = O_DEV_WE && O_DEV_ADDR == 16'hFF80;
    wire arr_wr = O_DEV_WE && !O_DEV_ADDR[15];
    ////////////////////////////////////////////////////////////////////////
    // Gap counts cycles since the last device write, saturating
    always @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            mode_q <= 8'h00;
            gap_q <= 16'h0000;
            last_q <= 16'h0000;
            lat_q <= 16'h0000;
            plen_q <= 16'h0000;
        end else begin
            if (O_DEV_WE) begin
                gap_q <= 16'h0001;
                last_q <= O_DEV_ADDR;
            end else if (gap_q != 16'hFFFF) begin
                gap_q <= gap_q + 16'h0001;
            end
            if (mode_wr) begin
                mode_q <= O_DEV_WDATA;
                plen_q <= 16'h0001;
            end else if (plen_q != 16'hFFFF) begin
                plen_q <= plen_q + 16'h0001;
            end
            if (arr_wr) begin
                lat_q <= O_DEV_ADDR;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_NRST);
    no_pulse_read_a: assert property ((mode_q[0] || mode_q[1]) |-> !O_DEV_RE)
        else $error("array read while a pulse bit is set");
    arm_pulse_a: assert property
        (mode_wr && O_DEV_WDATA == 8'h01 |-> ##[0:1] O_WDOG_ARM)
        else $error("program pulse without watchdog armed");
    arm_erase_a: assert property
        (mode_wr && O_DEV_WDATA == 8'h02 |-> ##[0:1] O_WDOG_ARM)
        else $error("erase pulse without watchdog armed");
    pulse_len_a: assert property (mode_wr && mode_q == 8'h01 |->
        plen_q >= 16'h03E8 && plen_q <= 16'h03F2)
        else $error("program pulse length wrong");
    pulse_end_a: assert property
        (mode_q == 8'h01 |-> plen_q <= 16'h03F2)
        else $error("program pulse not cleared");
    check_wait_a: assert property
        (O_DEV_RE && mode_q == 8'h04 |-> gap_q >= 16'h0190)
        else $error("program check read too early");
    check_addr_a: assert property
        (O_DEV_RE && mode_q == 8'h04 |-> O_DEV_ADDR == lat_q)
        else $error("program check read not at latched address");
    dummy_ones_a: assert property
        (arr_wr && mode_q == 8'h08 |-> O_DEV_WDATA == 8'hFF)
        else $error("erase check dummy write not all ones");
    dummy_wait_a: assert property (O_DEV_RE && mode_q == 8'h08 |->
        gap_q >= 16'h00C8 && last_q == O_DEV_ADDR)
        else $error("erase check read too early or elsewhere");
    first_dummy_a: assert property (arr_wr && mode_q == 8'h08 &&
        last_q == 16'hFF80 |-> gap_q >= 16'h0190)
        else $error("first dummy write too early");
    addr_range_a: assert property (O_DEV_WE && O_DEV_ADDR[15] |->
        O_DEV_ADDR inside {16'hFF80, 16'hFF82, 16'hFF83})
        else $error("write outside array and control registers");
    one_mode_a: assert property (mode_wr |-> $onehot0(O_DEV_WDATA) &&
        (O_DEV_WDATA == 8'h00 || mode_q == 8'h00))
        else $error("mode bits overlap");
endmodule
bind fpec_ctrl fpec_ctrl_asserts u_chk (.I_CLK(I_CLK), .I_NRST(I_NRST),
    .O_DEV_ADDR(O_DEV_ADDR), .O_DEV_WDATA(O_DEV_WDATA),
    .O_DEV_WE(O_DEV_WE), .O_DEV_RE(O_DEV_RE), .O_WDOG_ARM(O_WDOG_ARM));

//--- bench/fpec_flash_model.sv
// Behavioural flash array with mode control and block select registers.
// Assumes read data is wanted the cycle after the read strobe.
module fpec_flash_model (
    // Clock and reset
    input wire i_clk,
    input wire i_nrst,
    // Device bus
    input wire [15:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_we,
    input wire i_re,
    output reg [7:0] o_rdata,
    // Pulses that fail to take effect
    input wire [7:0] i_prog_miss,
    input wire [7:0] i_erase_miss
);
    timeunit 1ns;
    timeprecision 1ps;
    // Only 256 cells: higher addresses alias, enough for short ranges
    reg [7:0] mem [0:255];
    reg [7:0] mode_q, sel1_q, sel2_q, lat_d_q, pmiss_q, emiss_q;
    reg [15:0] lat_a_q;
    integer i;
    initial for (i = 0; i < 256; i = i + 1) mem[i] = 8'hFF;
    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            {mode_q, sel1_q, sel2_q, lat_d_q, pmiss_q, emiss_q} <= 48'h0;
            lat_a_q <= 16'h0000;
            o_rdata <= 8'h00;
        end else begin
            if (i_we && i_addr == 16'hFF80) begin
                mode_q <= i_wdata;
                if (mode_q[0] && !i_wdata[0]) begin
                    if (pmiss_q < i_prog_miss) pmiss_q <= pmiss_q + 8'h01;
                    else mem[lat_a_q[7:0]] <= mem[lat_a_q[7:0]] & lat_d_q;
                end
                if (mode_q[1] && !i_wdata[1] && (sel1_q | sel2_q) != 0) begin
                    if (emiss_q < i_erase_miss) emiss_q <= emiss_q + 8'h01;
                    else for (i = 0; i < 256; i = i + 1) mem[i] <= 8'hFF;
                end
            end else if (i_we && i_addr == 16'hFF82) sel1_q <= i_wdata;
            else if (i_we && i_addr == 16'hFF83) sel2_q <= i_wdata;
            else if (i_we && !i_addr[15]) begin
                lat_a_q <= i_addr;
                lat_d_q <= i_wdata;
            end
            // Idle or blocked reads give a toggling pattern, not stale data
            if (i_re && (mode_q[0] || mode_q[1])) o_rdata <= ~o_rdata;
            else if (i_re && (mode_q[2] || mode_q[3]))
                o_rdata <= mem[lat_a_q[7:0]];
            else if (i_re) o_rdata <= mem[i_addr[7:0]];
            else o_rdata <= ~o_rdata;
        end
    end
endmodule

//--- bench/fpec_ctrl_test.sv
// Testbench for the flash sequencer: host register tasks and scenarios.
// Assumes the flash model answers on the device bus and the bound checker.
module fpec_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_we = 1'b0;
    logic reg_re = 1'b0;
    logic [7:0] prog_miss = 8'h00;
    logic [7:0] erase_miss = 8'h01;
    wire [15:0] reg_rdata, dev_addr;
    wire [7:0] dev_wdata, dev_rdata;
    wire dev_we, dev_re, wdog_arm, busy;
    int n_errors = 0;
    int cmp_count = 0;
    int n_erase = 0, n_zero = 0, n_ff = 0, n_arr = 0, n_dwr = 0, base, k;
    logic [15:0] rv;
    fpec_ctrl #(.ERASE_CYCLES(20'h00014)) dut (.I_CLK(clk), .I_NRST(nrst),
        .I_REG_ADDR(reg_addr), .I_REG_WDATA(reg_wdata), .I_REG_WE(reg_we),
        .I_REG_RE(reg_re), .O_REG_RDATA(reg_rdata), .O_DEV_ADDR(dev_addr),
        .O_DEV_WDATA(dev_wdata), .O_DEV_WE(dev_we), .O_DEV_RE(dev_re),
        .I_DEV_RDATA(dev_rdata), .O_WDOG_ARM(wdog_arm), .O_BUSY(busy));
    fpec_flash_model u_flash (.i_clk(clk), .i_nrst(nrst), .i_addr(dev_addr),
        .i_wdata(dev_wdata), .i_we(dev_we), .i_re(dev_re),
        .o_rdata(dev_rdata), .i_prog_miss(prog_miss),
        .i_erase_miss(erase_miss));
    always #5 clk = ~clk;
    always @(posedge clk) begin
        if (dev_we) begin
            n_dwr++;
            if (dev_addr == 16'hFF80 && dev_wdata == 8'h02) n_erase++;
            if (!dev_addr[15]) n_arr++;
            if (!dev_addr[15] && dev_wdata == 8'h00) n_zero++;
            if (!dev_addr[15] && dev_wdata == 8'hFF) n_ff++;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task wr(input [7:0] a, input [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_we <= 1'b1;
        @(posedge clk);
        reg_we <= 1'b0;
    endtask
    task chk(input string name, input [15:0] exp, input [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task rchk(input [7:0] a, input [15:0] exp, input string name);
        @(posedge clk);
        reg_addr <= a;
        reg_re <= 1'b1;
        @(posedge clk);
        reg_re <= 1'b0;
        #1 rv = reg_rdata;
        chk(name, exp, rv);
    endtask
    // Bounded wait so a stuck sequence cannot hang the run
    task wait_idle;
        #1 k = 0;
        while (busy !== 1'b0 && k < 20000) begin
            @(posedge clk);
            #1 k++;
        end
        if (k == 20000) begin
            n_errors++;
            $display("ERROR busy expected 0 seen %b", busy);
        end
    endtask
    task prog(input [15:0] a, input [15:0] d);
        wr(8'h0C, 16'h0001);
        wr(8'h04, a);
        wr(8'h08, d);
        wr(8'h00, 16'h0001);
        wait_idle;
    endtask
    task complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        #400000;
        n_errors++;
        $display("ERROR watchdog expected finish seen timeout");
        complete_run;
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        rchk(8'h14, 16'h0000, "status");
        rchk(8'h20, 16'h0000, "unmapped");
        $display("test reset done");
        prog(16'h0012, 16'h005A);
        rchk(8'h14, 16'h0002, "status");
        rchk(8'h1C, 16'h005A, "lastrd");
        chk("array", 16'h005A, {8'h00, u_flash.mem[8'h12]});
        chk("blksel", 16'h0000, {u_flash.sel2_q, u_flash.sel1_q});
        chk("mode", 16'h0000, {8'h00, u_flash.mode_q});
        $display("test program done");
        prog_miss <= 8'h02;
        base = n_arr;
        prog(16'h0034, 16'h00C3);
        rchk(8'h14, 16'h0002, "status");
        chk("attempts", 16'h0003, 16'(n_arr - base));
        rchk(8'h18, 16'h0003, "tries");
        chk("array", 16'h00C3, {8'h00, u_flash.mem[8'h34]});
        $display("test retry done");
        base = n_dwr;
        wr(8'h04, 16'h8000);
        wr(8'h00, 16'h0001);
        #1 chk("busy", 16'h0000, {15'h0000, busy});
        rchk(8'h14, 16'h000C, "status");
        chk("devwrites", 16'h0000, 16'(n_dwr - base));
        wr(8'h04, 16'h0010);
        wr(8'h00, 16'h0003);
        #1 chk("busy", 16'h0000, {15'h0000, busy});
        $display("test refuse done");
        wr(8'h10, 16'h0013);
        wr(8'h00, 16'h0002);
        wait_idle;
        rchk(8'h14, 16'h0002, "status");
        chk("erases", 16'h0002, 16'(n_erase));
        rchk(8'h18, 16'h0002, "tries");
        chk("prewrites", 16'h0004, 16'(n_zero));
        chk("dummies", 16'h0005, 16'(n_ff));
        for (int a = 16; a < 20; a++)
            chk("erased", 16'h00FF, {8'h00, u_flash.mem[a]});
        $display("test erase done");
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        rchk(8'h14, 16'h0000, "status");
        $display("test second reset done");
        complete_run;
    end
endmodule
